/* File: design/mfp_pkg.sv */
// shared constants, enumerations and carriers for the mmu miss/fault/probe control
package mfp_pkg;
  localparam int ADDR_W = 32;
  localparam int PAGE_W = 20;
  localparam int OFFS_W = 12;
  localparam int NENT = 32;
  localparam int IDX_W = 6;
  localparam int CMD_W = 5;
  localparam logic [CMD_W-1:0] CMD_PROBE_SUPER = 5'h08;
  localparam logic [CMD_W-1:0] CMD_PROBE_USER = 5'h09;
  localparam int LOW_SP_BIT = 8;
  localparam int LOW_WP_BIT = 2;
  localparam int UP_SU_BIT = 0;
  localparam logic [ADDR_W-1:0] WORD_ZERO = 32'h0000_0000;

  // control register selects on the load/store port
  typedef enum logic [2:0] {
    CR_INDEX = 3'b000,
    CR_UPPER = 3'b001,
    CR_LOWER = 3'b010,
    CR_PROBE_ADDR = 3'b011,
    CR_COMMAND = 3'b100,
    CR_STATUS = 3'b101,
    CR_PADDR = 3'b110,
    CR_MISS_ADDR = 3'b111
  } mfp_cr_sel_t;

  // tablewalk error kinds
  typedef enum logic [1:0] {
    WERR_NONE = 2'b00,
    WERR_SEG_INV = 2'b01,
    WERR_PAGE_INV = 2'b10,
    WERR_BUS = 2'b11
  } mfp_werr_t;

  // probe sequencer states
  typedef enum logic [1:0] {
    PR_IDLE = 2'b00,
    PR_SEARCH = 2'b01,
    PR_WALK = 2'b10
  } mfp_pstate_t;

  typedef struct packed {
    logic vld;
    logic [ADDR_W-1:0] laddr;
    logic su;
  } mfp_miss_t;

  typedef struct packed {
    logic bus_err;
    logic cpb_err;
    logic wal_err;
    logic [ADDR_W-1:0] paddr;
  } mfp_acc_err_t;

  typedef struct packed {
    logic done;
    logic probe;
    mfp_werr_t err;
    logic sp_viol;
    logic wp_viol;
    logic [ADDR_W-1:0] desc_addr;
    logic [ADDR_W-1:0] lower;
  } mfp_walk_t;

  typedef struct packed {
    logic hit;
    logic [ADDR_W-1:0] paddr;
    logic sp;
    logic wp;
  } mfp_blk_t;

  typedef struct packed {
    logic [PAGE_W-1:0] lpa;
    logic su;
  } mfp_upper_t;

  typedef struct packed {
    logic vld;
    mfp_upper_t up;
    logic [ADDR_W-1:0] lower;
  } mfp_entry_t;

  typedef struct packed {
    logic bus_error_bit;
    logic mmu_fault;
    logic copyback_error_bit;
    logic write_alloc_error_bit;
    logic page_cache_hit;
    logic block_cache_hit;
    logic seg_invalid;
    logic page_invalid;
    logic walk_bus_err;
    logic supervisor_protect_status;
    logic write_protect;
  } mfp_status_t;

  localparam int STAT_W = $bits(mfp_status_t);
endpackage

/* File: design/mfp_repl_fifo.sv */
// first-in first-out replacement pointer for the page translation cache
`timescale 1ns/10ps
module mfp_repl_fifo import mfp_pkg::*; #(
  parameter int ENTRIES = NENT
) (
  input wire logic clk_sys_i, // core clock
  input wire logic srst_i, // sync reset
  input wire logic adv_i, // victim consumed
  output logic [IDX_W-1:0] victim_o // entry to replace next
);
  typedef struct packed {
    logic [IDX_W-1:0] ptr;
  } mfp_fifo_state_t;

  mfp_fifo_state_t r_reg;
  mfp_fifo_state_t r_next;

  // step round the entries in fill order
  always_comb begin
    r_next = r_reg;
    if (adv_i) begin
      if (r_reg.ptr == IDX_W'(ENTRIES - 1)) begin
        r_next.ptr = '0;
      end else begin
        r_next.ptr = r_reg.ptr + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign victim_o = r_reg.ptr;
endmodule

/* File: design/mfp_xlate_cache.sv */
// page translation cache array with tag search, write, invalidate and read ports
`timescale 1ns/10ps
module mfp_xlate_cache import mfp_pkg::*; #(
  parameter int ENTRIES = NENT
) (
  input wire logic clk_sys_i, // core clock
  input wire logic srst_i, // sync reset, clears valid bits
  input wire logic [PAGE_W-1:0] look_lpa_i, // searched page
  input wire logic look_su_i, // searched space
  output logic look_hit_o, // search hit
  output logic [IDX_W-1:0] look_idx_o, // hit entry
  output logic [ADDR_W-1:0] look_lower_o, // hit entry lower word
  input wire logic wr_i, // write entry
  input wire logic [IDX_W-1:0] wr_idx_i, // write entry number
  input wire mfp_entry_t wr_entry_i, // write contents
  input wire logic inv_i, // invalidate entry
  input wire logic [IDX_W-1:0] inv_idx_i, // invalidated entry number
  input wire logic [IDX_W-1:0] rd_idx_i, // read entry number
  output mfp_entry_t rd_entry_o // read contents
);
  typedef struct packed {
    mfp_entry_t [ENTRIES-1:0] ent;
  } mfp_cache_state_t;

  mfp_cache_state_t r_reg;
  mfp_cache_state_t r_next;
  logic [ENTRIES-1:0] match;

  // per-entry tag compare
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_match
      assign match[g] = r_reg.ent[g].vld && r_reg.ent[g].up == {look_lpa_i, look_su_i};
    end
  endgenerate

  // encode the hit, lowest entry wins
  always_comb begin
    look_hit_o = |match;
    look_idx_o = '0;
    look_lower_o = WORD_ZERO;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        look_idx_o = IDX_W'(i);
        look_lower_o = r_reg.ent[i].lower;
      end
    end
  end

  // writes and invalidations; indices past the array are ignored
  always_comb begin
    r_next = r_reg;
    if (inv_i && inv_idx_i < IDX_W'(ENTRIES)) begin
      r_next.ent[inv_idx_i].vld = 1'b0;
    end
    if (wr_i && wr_idx_i < IDX_W'(ENTRIES)) begin
      r_next.ent[wr_idx_i] = wr_entry_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_entry_o = (rd_idx_i < IDX_W'(ENTRIES)) ? r_reg.ent[rd_idx_i] : '0;
endmodule

/* File: design/mfp_ctrl.sv */
// miss refill, entry port, fault capture and probe control of one mmu side
// Notes on behaviour
// - with software refill on, a miss raises the dedicated miss trap
// - a miss captures the faulting virtual address
// - a miss writes the replacement entry number into the index register
// - a miss preloads the upper buffer with missed page and space
// - the upper buffer enters the cache only on a lower-word write
// - upper port returns the buffer, held until an upper write, a lower read or a new miss
// - ordinary bus error sets bus error bit, captures address, raises exception
// - non-probe walk faults set the fault bit and raise an exception
// - invalid descriptor aborts walk and captures descriptor address
// - walk bus error aborts walk and captures failing address
// - protection violations finish the walk, then fault with descriptor address
// - failed data copyback sets copyback bit, captures address, raises exception
// - write-allocate bus error sets its bit, captures address, raises exception
// - translation off: probe searches both caches, no walk, miss clears hits
// - translation on with block hit: probe reports status and address
// - no block hit, walks on: probe always walks, and fills the entry when the walk is clean
// - probe walk error invalidates a matching entry, never creates one
// - no block hit, walks off: probe reports only on page cache hit
// - replacement follows first-in first-out order
// - probe errors never raise an access exception
// - command code is the low five bits; command reads return zero
`timescale 1ns/10ps
module mfp_ctrl import mfp_pkg::*; #(
  parameter bit IS_DATA = 1'b1
) (
  input wire logic clk_sys_i, // core clock
  input wire logic srst_i, // sync reset
  input wire logic sw_refill_on_i, // software refill enable
  input wire logic translation_on_i, // translation enable
  input wire logic hw_walk_on_i, // hardware walk enable
  input wire logic cr_wr_i, // control register store
  input wire logic cr_rd_i, // control register load
  input wire mfp_cr_sel_t cr_sel_i, // register select
  input wire logic [ADDR_W-1:0] cr_wdata_i, // store data
  output logic [ADDR_W-1:0] cr_rdata_o, // load data
  input wire mfp_miss_t miss_i, // translation miss event
  output logic miss_trap_o, // software refill trap pulse
  output logic hw_fill_req_o, // hardware refill walk pulse
  input wire mfp_acc_err_t acc_err_i, // ordinary access errors
  input wire mfp_walk_t walk_i, // walker result
  output logic walk_abort_o, // abort walk pulse
  output logic access_exc_o, // access exception pulse
  input wire mfp_blk_t blk_i, // block cache search on probe address
  output logic [ADDR_W-1:0] probe_addr_o, // probe address
  output logic probe_su_o, // probe is supervisor
  output logic probe_walk_req_o, // probe walk request level
  output logic probe_busy_o, // probe running
  output mfp_status_t status_o, // access status
  output logic [ADDR_W-1:0] paddr_capture_o, // captured physical address
  output logic [ADDR_W-1:0] miss_laddr_o, // captured miss address
  output logic [IDX_W-1:0] entry_index_o // entry index register
);
  typedef struct packed {
    mfp_pstate_t pst;
    logic [IDX_W-1:0] idx;
    mfp_upper_t upbuf;
    logic [ADDR_W-1:0] miss_addr;
    logic [ADDR_W-1:0] probe_addr;
    logic probe_su;
    logic probe_hit;
    logic [IDX_W-1:0] probe_idx;
    mfp_status_t stat;
    logic [ADDR_W-1:0] paddr;
    logic [ADDR_W-1:0] rdata;
    logic trap;
    logic fill_req;
    logic exc;
    logic abort;
  } mfp_ctrl_state_t;

  mfp_ctrl_state_t r_reg;
  mfp_ctrl_state_t r_next;
  logic [IDX_W-1:0] victim;
  logic fifo_adv;
  logic look_hit;
  logic [IDX_W-1:0] look_idx;
  logic [ADDR_W-1:0] look_lower;
  logic cam_wr;
  logic [IDX_W-1:0] cam_wr_idx;
  mfp_entry_t cam_wr_entry;
  logic cam_inv;
  mfp_entry_t cam_rd;
  logic [CMD_W-1:0] cmd;

  assign cmd = cr_wdata_i[CMD_W-1:0];

  mfp_repl_fifo #(.ENTRIES(NENT)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .adv_i(fifo_adv),
    .victim_o(victim)
  );

  mfp_xlate_cache #(.ENTRIES(NENT)) u_cache (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .look_lpa_i(r_reg.probe_addr[ADDR_W-1:OFFS_W]),
    .look_su_i(r_reg.probe_su),
    .look_hit_o(look_hit),
    .look_idx_o(look_idx),
    .look_lower_o(look_lower),
    .wr_i(cam_wr),
    .wr_idx_i(cam_wr_idx),
    .wr_entry_i(cam_wr_entry),
    .inv_i(cam_inv),
    .inv_idx_i(r_reg.probe_idx),
    .rd_idx_i(r_reg.idx),
    .rd_entry_o(cam_rd)
  );

  // next state: software access first, hardware events after so a set beats a clear
  always_comb begin
    r_next = r_reg;
    r_next.trap = 1'b0;
    r_next.fill_req = 1'b0;
    r_next.exc = 1'b0;
    r_next.abort = 1'b0;
    cam_wr = 1'b0;
    cam_wr_idx = r_reg.idx;
    cam_wr_entry = '0;
    cam_inv = 1'b0;
    fifo_adv = 1'b0;
    // control register loads
    if (cr_rd_i) begin
      case (cr_sel_i)
        CR_INDEX: r_next.rdata = ADDR_W'(r_reg.idx);
        CR_UPPER: r_next.rdata = {r_reg.upbuf.lpa, {(OFFS_W-1){1'b0}}, r_reg.upbuf.su};
        CR_LOWER: begin
          r_next.rdata = cam_rd.lower;
          r_next.upbuf = cam_rd.up;
        end
        CR_PROBE_ADDR: r_next.rdata = r_reg.probe_addr;
        CR_COMMAND: r_next.rdata = WORD_ZERO;
        CR_STATUS: r_next.rdata = ADDR_W'(r_reg.stat);
        CR_PADDR: r_next.rdata = r_reg.paddr;
        CR_MISS_ADDR: r_next.rdata = r_reg.miss_addr;
        default: r_next.rdata = WORD_ZERO;
      endcase
    end
    // control register stores
    if (cr_wr_i) begin
      case (cr_sel_i)
        CR_INDEX: r_next.idx = cr_wdata_i[IDX_W-1:0];
        CR_UPPER: begin
          r_next.upbuf.lpa = cr_wdata_i[ADDR_W-1:OFFS_W];
          r_next.upbuf.su = cr_wdata_i[UP_SU_BIT];
        end
        CR_LOWER: begin
          cam_wr = 1'b1;
          cam_wr_entry = {1'b1, r_reg.upbuf, cr_wdata_i};
        end
        CR_PROBE_ADDR: r_next.probe_addr = cr_wdata_i;
        CR_COMMAND: begin
          if (r_reg.pst == PR_IDLE && (cmd == CMD_PROBE_SUPER || cmd == CMD_PROBE_USER)) begin
            r_next.pst = PR_SEARCH;
            r_next.probe_su = (cmd == CMD_PROBE_SUPER);
          end
        end
        CR_STATUS: r_next.stat = r_reg.stat & ~mfp_status_t'(cr_wdata_i[STAT_W-1:0]);
        default: ;
      endcase
    end
    // translation miss
    if (miss_i.vld) begin
      r_next.miss_addr = miss_i.laddr;
      r_next.idx = victim;
      fifo_adv = 1'b1;
      r_next.upbuf = {miss_i.laddr[ADDR_W-1:OFFS_W], miss_i.su};
      r_next.trap = sw_refill_on_i;
      r_next.fill_req = ~sw_refill_on_i;
    end
    // ordinary access errors
    if (acc_err_i.bus_err) begin
      r_next.stat.bus_error_bit = 1'b1;
      r_next.paddr = acc_err_i.paddr;
      r_next.exc = 1'b1;
    end
    if (IS_DATA && acc_err_i.cpb_err) begin
      r_next.stat.copyback_error_bit = 1'b1;
      r_next.paddr = acc_err_i.paddr;
      r_next.exc = 1'b1;
    end
    if (IS_DATA && acc_err_i.wal_err) begin
      r_next.stat.write_alloc_error_bit = 1'b1;
      r_next.paddr = acc_err_i.paddr;
      r_next.exc = 1'b1;
    end
    // end of a normal tablewalk
    if (walk_i.done && !walk_i.probe) begin
      if (walk_i.err != WERR_NONE) begin
        r_next.abort = 1'b1;
        r_next.stat.mmu_fault = 1'b1;
        r_next.exc = 1'b1;
        r_next.paddr = walk_i.desc_addr;
      end else begin
        cam_wr = 1'b1;
        cam_wr_idx = r_reg.idx;
        cam_wr_entry = {1'b1, r_reg.miss_addr[ADDR_W-1:OFFS_W], r_reg.upbuf.su, walk_i.lower};
        if (walk_i.sp_viol || (IS_DATA && walk_i.wp_viol)) begin
          r_next.stat.mmu_fault = 1'b1;
          r_next.exc = 1'b1;
          r_next.paddr = walk_i.desc_addr;
        end
      end
    end
    // probe sequencer
    case (r_reg.pst)
      PR_IDLE: ;
      PR_SEARCH: begin
        r_next.pst = PR_IDLE;
        if (blk_i.hit) begin
          r_next.stat.block_cache_hit = 1'b1;
          r_next.stat.page_cache_hit = 1'b0;
          r_next.stat.supervisor_protect_status = blk_i.sp;
          r_next.stat.write_protect = blk_i.wp;
          r_next.paddr = blk_i.paddr;
        end else if (translation_on_i && hw_walk_on_i) begin
          r_next.pst = PR_WALK;
          r_next.probe_hit = look_hit;
          r_next.probe_idx = look_idx;
        end else if (look_hit) begin
          r_next.stat.page_cache_hit = 1'b1;
          r_next.stat.block_cache_hit = 1'b0;
          r_next.stat.supervisor_protect_status = look_lower[LOW_SP_BIT];
          r_next.stat.write_protect = look_lower[LOW_WP_BIT];
          r_next.paddr = {look_lower[ADDR_W-1:OFFS_W], r_reg.probe_addr[OFFS_W-1:0]};
        end else begin
          r_next.stat.page_cache_hit = 1'b0;
          r_next.stat.block_cache_hit = 1'b0;
        end
      end
      PR_WALK: begin
        if (walk_i.done && walk_i.probe) begin
          r_next.pst = PR_IDLE;
          r_next.stat.block_cache_hit = 1'b0;
          if (walk_i.err != WERR_NONE) begin
            r_next.stat.page_cache_hit = 1'b0;
            r_next.stat.seg_invalid = (walk_i.err == WERR_SEG_INV);
            r_next.stat.page_invalid = (walk_i.err == WERR_PAGE_INV);
            r_next.stat.walk_bus_err = (walk_i.err == WERR_BUS);
            r_next.paddr = walk_i.desc_addr;
            cam_inv = r_reg.probe_hit;
          end else begin
            cam_wr = 1'b1;
            cam_wr_idx = r_reg.probe_hit ? r_reg.probe_idx : victim;
            fifo_adv = ~r_reg.probe_hit;
            cam_wr_entry = {1'b1, r_reg.probe_addr[ADDR_W-1:OFFS_W], r_reg.probe_su, walk_i.lower};
            r_next.stat.page_cache_hit = 1'b1;
            r_next.stat.supervisor_protect_status = walk_i.lower[LOW_SP_BIT];
            r_next.stat.write_protect = walk_i.lower[LOW_WP_BIT];
            r_next.paddr = {walk_i.lower[ADDR_W-1:OFFS_W], r_reg.probe_addr[OFFS_W-1:0]};
          end
        end
      end
      default: r_next.pst = PR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign cr_rdata_o = r_reg.rdata;
  assign miss_trap_o = r_reg.trap;
  assign hw_fill_req_o = r_reg.fill_req;
  assign walk_abort_o = r_reg.abort;
  assign access_exc_o = r_reg.exc;
  assign probe_addr_o = r_reg.probe_addr;
  assign probe_su_o = r_reg.probe_su;
  assign probe_walk_req_o = (r_reg.pst == PR_WALK);
  assign probe_busy_o = (r_reg.pst != PR_IDLE);
  assign status_o = r_reg.stat;
  assign paddr_capture_o = r_reg.paddr;
  assign miss_laddr_o = r_reg.miss_addr;
  assign entry_index_o = r_reg.idx;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_trap;
    miss_i.vld && sw_refill_on_i |=> miss_trap_o && !hw_fill_req_o;
  endproperty
  a_trap: assert property (p_trap) else $error("miss did not trap");
  property p_miss_addr;
    miss_i.vld |=> miss_laddr_o == $past(miss_i.laddr);
  endproperty
  a_miss_addr: assert property (p_miss_addr) else $error("miss address lost");
  property p_miss_idx;
    miss_i.vld |=> entry_index_o == $past(victim) && victim != $past(victim);
  endproperty
  a_miss_idx: assert property (p_miss_idx) else $error("index not victim");
  property p_preload;
    miss_i.vld |=> r_reg.upbuf.lpa == $past(miss_i.laddr[ADDR_W-1:OFFS_W]);
  endproperty
  a_preload: assert property (p_preload) else $error("upper not preloaded");
  property p_commit;
    cam_wr |-> (cr_wr_i && cr_sel_i == CR_LOWER) || walk_i.done;
  endproperty
  a_commit: assert property (p_commit) else $error("entry written without lower");
  property p_hold;
    !$stable(r_reg.upbuf) |-> $past(miss_i.vld || (cr_rd_i && cr_sel_i == CR_LOWER)
      || (cr_wr_i && cr_sel_i == CR_UPPER));
  endproperty
  a_hold: assert property (p_hold) else $error("upper buffer changed");
  property p_bus_err;
    acc_err_i.bus_err |=> status_o.bus_error_bit && access_exc_o;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error not flagged");
  property p_abort;
    walk_i.done && !walk_i.probe && walk_i.err != WERR_NONE
      |=> walk_abort_o && access_exc_o && status_o.mmu_fault;
  endproperty
  a_abort: assert property (p_abort) else $error("walk fault not handled");
  property p_probe_quiet;
    walk_i.done && walk_i.probe && r_reg.pst == PR_WALK && !acc_err_i.bus_err
      && !acc_err_i.cpb_err && !acc_err_i.wal_err |=> !access_exc_o;
  endproperty
  a_probe_quiet: assert property (p_probe_quiet) else $error("probe raised exception");
  property p_cmd_zero;
    cr_rd_i && cr_sel_i == CR_COMMAND |=> cr_rdata_o == WORD_ZERO;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
  property p_no_walk_off;
    r_reg.pst == PR_SEARCH && !translation_on_i |=> !probe_walk_req_o ##1 !probe_walk_req_o;
  endproperty
  a_no_walk_off: assert property (p_no_walk_off) else $error("walk with translation off");

  c_probe_walk: cover property (r_reg.pst == PR_WALK ##1 r_reg.pst == PR_IDLE);
  c_sw_refill: cover property (miss_trap_o ##[1:20] (cr_wr_i && cr_sel_i == CR_LOWER));
  c_blk_probe: cover property (r_reg.pst == PR_SEARCH && blk_i.hit);
endmodule

/* File: sim/mfp_walk_model.sv */
// walker and block cache model facing the miss, fault and probe control
`timescale 1ns/10ps
module mfp_walk_model import mfp_pkg::*; (
  input wire logic clk_sys_i, // core clock
  input wire logic req_i, // probe walk request level
  input wire logic nrm_i, // start a normal walk
  input wire mfp_werr_t err_i, // error reported by the next normal or probe walk
  input wire logic [ADDR_W-1:0] probe_addr_i, // probe address
  output mfp_walk_t walk_o, // walk result
  output mfp_blk_t blk_o // block search result
);
  logic [2:0] cnt_reg = 3'h0;
  logic prb_reg = 1'b0;
  initial walk_o = '0;
  // block cache maps the 0xB region; a miss shows a scrambled address
  assign blk_o = '{probe_addr_i[31:28] == 4'hB,
    (probe_addr_i[31:28] == 4'hB) ? {12'h007, probe_addr_i[19:0]} : ~probe_addr_i, 1'b1, 1'b0};
  // answer a walk three cycles after it starts; idle result fields keep changing
  // a clean normal walk reports a supervisor violation, probe walks carry err_i too
  always @(posedge clk_sys_i) begin
    walk_o.done <= 1'b0;
    walk_o.desc_addr <= ~walk_o.desc_addr;
    walk_o.lower <= ~walk_o.lower;
    if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        walk_o <= '{1'b1, prb_reg, err_i, !prb_reg && err_i == WERR_NONE, 1'b0,
          32'h0000_4A40, 32'hABCD_E001};
      end
    end else if (nrm_i || (req_i && !walk_o.done)) begin
      cnt_reg <= 3'h3;
      prb_reg <= !nrm_i;
    end
  end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the miss, fault and probe control
`timescale 1ns/10ps
`define CHK(o, e) begin total_checks++; exp_v = (e); if ((o) !== exp_v) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, o, exp_v); end end
module tb_top import mfp_pkg::*; ;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, sw_on = 1'b0, tr_on = 1'b0, hw_on = 1'b0;
  logic cr_wr = 1'b0, cr_rd = 1'b0, nrm = 1'b0, rd_d = 1'b0, busy_d = 1'b0;
  logic trap, fill, abort, exc, busy, preq, psu;
  mfp_cr_sel_t sel = CR_INDEX;
  logic [31:0] wd = '0, rdata, paddr_c, mladdr, praddr, laddr, a, d, u;
  logic [5:0] idx;
  mfp_miss_t miss = '0;
  mfp_acc_err_t aerr = '0;
  mfp_werr_t werr = WERR_NONE;
  mfp_walk_t walk;
  mfp_blk_t blk;
  mfp_status_t st;
  logic [42:0] q[$];
  logic [42:0] exp_v;
  logic [10:0] eb [3] = '{11'h400, 11'h100, 11'h080};
  mfp_werr_t wk [4] = '{WERR_SEG_INV, WERR_PAGE_INV, WERR_BUS, WERR_NONE};
  int miscompares = 0, total_checks = 0;
  int n_abort = 0;
  mfp_ctrl uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sw_refill_on_i(sw_on),
    .translation_on_i(tr_on), .hw_walk_on_i(hw_on), .cr_wr_i(cr_wr), .cr_rd_i(cr_rd),
    .cr_sel_i(sel), .cr_wdata_i(wd), .cr_rdata_o(rdata), .miss_i(miss), .miss_trap_o(trap),
    .hw_fill_req_o(fill), .acc_err_i(aerr), .walk_i(walk), .walk_abort_o(abort),
    .access_exc_o(exc), .blk_i(blk), .probe_addr_o(praddr), .probe_su_o(psu),
    .probe_walk_req_o(preq), .probe_busy_o(busy), .status_o(st), .paddr_capture_o(paddr_c),
    .miss_laddr_o(mladdr), .entry_index_o(idx));
  mfp_walk_model far (.clk_sys_i(clk_sys_i), .req_i(preq), .nrm_i(nrm), .err_i(werr),
    .probe_addr_i(praddr), .walk_o(walk), .blk_o(blk));
  // core clock
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [42:0] pop();
    return (q.size() != 0) ? q.pop_front() : 'x;
  endfunction
  task automatic wr(mfp_cr_sel_t s, logic [31:0] v);
    @(posedge clk_sys_i);
    cr_wr <= 1'b1;
    sel <= s;
    wd <= v;
    @(posedge clk_sys_i);
    cr_wr <= 1'b0;
  endtask
  task automatic rd(mfp_cr_sel_t s, logic [31:0] e);
    q.push_back({11'h0, e});
    @(posedge clk_sys_i);
    cr_rd <= 1'b1;
    sel <= s;
    @(posedge clk_sys_i);
    cr_rd <= 1'b0;
  endtask
  task automatic mis(logic su, logic sw, logic [5:0] ix);
    @(posedge clk_sys_i);
    laddr = $urandom;
    sw_on <= sw;
    miss <= '{1'b1, laddr, su};
    q.push_back({4'h0, sw, ix, laddr});
    @(posedge clk_sys_i);
    miss <= '0;
  endtask
  task automatic fin(string n);
    for (int i = 0; i < 60 && q.size() != 0; i++) @(posedge clk_sys_i);
    if (q.size() != 0) miscompares++;
    $display("test %s done", n);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // takes the oldest note whenever a result shows at the outputs
  always @(posedge clk_sys_i) begin
    if (rd_d) `CHK({11'h0, rdata}, pop())
    if (trap || fill) `CHK({4'h0, trap, idx, mladdr}, pop())
    if (exc) `CHK({st, paddr_c}, pop())
    if (busy_d && !busy) `CHK({11'h0, paddr_c}, pop())
    if (abort === 1'b1) n_abort++;
    rd_d = cr_rd;
    busy_d = busy;
  end
  // hang guard
  initial begin
    #80000;
    miscompares++;
    give_verdict();
  end
  // test sequence
  initial begin
    void'($urandom(32'h5D1B));
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    mis(1'b1, 1'b1, 6'h00);
    u = {laddr[31:12], 11'h0, 1'b1};
    rd(CR_UPPER, u);
    d = $urandom;
    wr(CR_LOWER, d);
    for (int k = 0; k < 4; k++) begin
      mis(1'b0, 1'b0, 6'(k + 1));
      @(posedge clk_sys_i);
      nrm <= 1'b1;
      werr <= wk[k];
      q.push_back({11'h200, 32'h0000_4A40});
      @(posedge clk_sys_i);
      nrm <= 1'b0;
      fin("walk fault");
    end
    wr(CR_INDEX, 32'h0);
    rd(CR_LOWER, d);
    rd(CR_UPPER, u);
    fin("entry port");
    for (int k = 0; k < 3; k++) begin
      wr(CR_STATUS, 32'h0000_07FF);
      a = $urandom;
      q.push_back({eb[k], a});
      @(posedge clk_sys_i);
      aerr <= '{k == 0, k == 1, k == 2, a};
      @(posedge clk_sys_i);
      aerr <= '0;
      fin("access error");
    end
    wr(CR_COMMAND, {$urandom} & 32'hFFFF_FFE0);
    rd(CR_COMMAND, 32'h0);
    tr_on <= 1'b1;
    a = {4'hB, 28'($urandom)};
    wr(CR_PROBE_ADDR, a);
    q.push_back({11'h0, 12'h007, a[19:0]});
    wr(CR_COMMAND, {27'($urandom), CMD_PROBE_SUPER});
    fin("probe block");
    `CHK({psu, st.block_cache_hit}, 2'b11)
    hw_on <= 1'b1;
    a = {4'h2, 28'($urandom)};
    wr(CR_PROBE_ADDR, a);
    d = {20'hABCDE, a[11:0]};
    q.push_back({11'h0, d});
    wr(CR_COMMAND, {27'h0, CMD_PROBE_USER});
    fin("probe walk");
    `CHK(psu, 1'b0)
    tr_on <= 1'b0;
    wr(CR_PROBE_ADDR, {4'h3, 28'($urandom)});
    q.push_back({11'h0, d});
    wr(CR_COMMAND, {27'h0, CMD_PROBE_USER});
    fin("probe off");
    `CHK({st.page_cache_hit, st.block_cache_hit}, 2'b00)
    tr_on <= 1'b1;
    hw_on <= 1'b0;
    a[11:0] = 12'($urandom);
    wr(CR_PROBE_ADDR, a);
    q.push_back({11'h0, 20'hABCDE, a[11:0]});
    wr(CR_COMMAND, {27'h0, CMD_PROBE_USER});
    fin("probe page");
    `CHK({st.page_cache_hit, st.block_cache_hit}, 2'b10)
    hw_on <= 1'b1;
    werr <= WERR_SEG_INV;
    wr(CR_PROBE_ADDR, a);
    q.push_back({11'h0, 32'h0000_4A40});
    wr(CR_COMMAND, {27'h0, CMD_PROBE_USER});
    fin("probe error");
    `CHK({st.seg_invalid, st.page_cache_hit}, 2'b10)
    hw_on <= 1'b0;
    wr(CR_PROBE_ADDR, a);
    q.push_back({11'h0, 32'h0000_4A40});
    wr(CR_COMMAND, {27'h0, CMD_PROBE_USER});
    fin("probe invalidated");
    `CHK(st.page_cache_hit, 1'b0)
    `CHK(n_abort, 3)
    give_verdict();
  end
endmodule
